// ### hdl/tdsr_pkg.sv
// package: register map, field layout and types for the tile debug status register bank
package tdsr_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_RING_CORE_CELL = 8'h07;
	localparam logic [ADDR_W-1:0] OFF_RING_CORE_WIRE = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RING_PERIPH_CELL = 8'h09;
	localparam logic [ADDR_W-1:0] OFF_RING_PERIPH_WIRE = 8'h0A;
	localparam logic [ADDR_W-1:0] OFF_MEMORY_SIZE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_SAVED_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_SAVED_PC = 8'h11;
	localparam logic [ADDR_W-1:0] OFF_SAVED_SP = 8'h12;
	localparam logic [ADDR_W-1:0] OFF_THREAD_SEL = 8'h13;
	localparam logic [ADDR_W-1:0] OFF_REG_SEL = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_ENTRY_CAUSE = 8'h15;
	localparam int RING_W = 16;
	localparam int NUM_RING = 4;
	localparam int STATUS_W = 11;
	// saved status word bit positions
	localparam int SSW_EVENT_EN = 0;
	localparam int SSW_IRQ_EN = 1;
	localparam int SSW_IN_ENB = 2;
	localparam int SSW_IN_HANDLER = 3;
	localparam int SSW_KERNEL = 4;
	localparam int SSW_PAUSED = 6;
	localparam int SSW_FAST = 7;
	localparam int SSW_ISSUE_MODE = 8;
	localparam int SSW_ISSUE_ON_ENTRY = 9;
	localparam int SSW_ASID = 10;
	// debug-writable bits of the saved status word (bit 8 and 5 excluded)
	localparam logic [STATUS_W-1:0] SSW_WRITE_MASK = 11'h6DF;
	// bits kept on capture: everything but reserved bit 5
	localparam logic [STATUS_W-1:0] SSW_CAPTURE_MASK = 11'h7DF;
	localparam int THREAD_W = 8;
	localparam int REGSEL_W = 5;
	localparam int CAUSE_W = 3;
	localparam int TRIG_W = 2;
	localparam int CAUSE_LSB = 0;
	localparam int THREAD_LSB = 8;
	localparam int TRIG_LSB = 16;
	localparam int NUM_TRIG = 4;
	localparam int MEM_LSB = 2;
	typedef enum logic [CAUSE_W-1:0] {
		TDSR_CAUSE_NONE = 3'h0,
		TDSR_CAUSE_HOST = 3'h1,
		TDSR_CAUSE_CALL = 3'h2,
		TDSR_CAUSE_IBREAK = 3'h3,
		TDSR_CAUSE_DWATCH = 3'h4,
		TDSR_CAUSE_RWATCH = 3'h5
	} tdsr_cause_t;
	// snapshot of the interrupted thread at debugger entry
	typedef struct packed {
		logic [STATUS_W-1:0] status;
		logic [DATA_W-1:0] pc;
		logic [DATA_W-1:0] sp;
		logic [THREAD_W-1:0] thread;
	} tdsr_entry_t;
	// configuration access request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tdsr_req_t;
endpackage : tdsr_pkg

// ### hdl/tdsr_bank.sv
// module: tile debug status register bank with ring oscillator counters
//
// Functional notes
// RULE1: ring counts are 16-bit, upper bits read zero
// RULE2: ring counts survive system reset
// RULE3: ring counts at four consecutive offsets 0x07-0x0A
// RULE4: memory size in bits 31:2, low bits zero
// RULE5: debugger entry captures saved status word
// RULE6: status bits 4,3,2: kernel, handler, enabling
// RULE7: status bits 1,0: irq/event enable, debug writable
// RULE8: status bits 7 fast, 6 paused, 10 asid
// RULE9: bit 8 read-only issue mode, bit 9 writable
// RULE10: entry captures 32-bit saved program counter
// RULE11: entry captures 32-bit saved stack pointer
// RULE12: 8-bit thread select for get-register op
// RULE13: 5-bit register select for get-register op
// RULE14: 3-bit cause code, resets to zero
// RULE15: 2-bit trigger number, zero for host/call
// RULE16: simultaneous triggers report lowest number
// RULE17: 8-bit cause thread, zero for host entry
// RULE18: software reads counts after ten stopped cycles
// RULE19: counters advance only while oscillator enabled
// RULE20: reserved bits read zero, ignore writes
`timescale 1ns/1ps
module tdsr_bank
	import tdsr_pkg::*;
#(
	parameter logic [DATA_W-1:0] MEMORY_BYTES = 32'h0008_0000
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_por_b,
	input wire tdsr_req_t i_req,
	output logic [DATA_W-1:0] o_rdata,
	output logic o_rvalid,
	input wire logic i_debug_mode,
	input wire logic i_core_osc_run,
	input wire logic i_periph_osc_run,
	input wire logic [NUM_RING-1:0] i_ring_tick,
	input wire logic i_dbg_entry,
	input wire tdsr_entry_t i_entry,
	input wire tdsr_cause_t i_entry_cause,
	input wire logic [NUM_TRIG-1:0] i_trig_hits,
	output logic [THREAD_W-1:0] o_read_thread_field,
	output logic [REGSEL_W-1:0] o_read_reg_field
);
	logic [RING_W-1:0] ring_counter_value [NUM_RING];
	logic [NUM_RING-1:0] ring_run;
	logic [STATUS_W-1:0] saved_status_word;
	logic [DATA_W-1:0] saved_program_counter;
	logic [DATA_W-1:0] saved_stack_pointer;
	logic [THREAD_W-1:0] read_thread_field;
	logic [REGSEL_W-1:0] read_reg_field;
	logic [CAUSE_W-1:0] cause_code;
	logic [THREAD_W-1:0] cause_thread;
	logic [TRIG_W-1:0] cause_trig;
	logic [TRIG_W-1:0] next_trig;
	logic [THREAD_W-1:0] next_thread;
	logic [DATA_W-1:0] next_rdata;
	logic wr_ok;

	// core oscillator feeds the first two counters, peripheral the last two
	assign ring_run = {i_periph_osc_run, i_periph_osc_run, i_core_osc_run, i_core_osc_run};

	// counters are cleared only by power-up, never by the system reset [RULE2]
	genvar g;
	generate
		for (g = 0; g < NUM_RING; g++) begin : g_ring
			always_ff @(posedge i_clk or negedge i_por_b) begin
				if (!i_por_b) begin
					ring_counter_value[g] <= '0;
				end else if (ring_run[g] && i_ring_tick[g]) begin // [RULE19]
					ring_counter_value[g] <= ring_counter_value[g] + 16'h0001;
				end
			end
		end
	endgenerate

	// debugger writes are honoured only in debug mode
	assign wr_ok = i_req.wr && i_debug_mode;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			saved_status_word <= '0;
		end else if (i_dbg_entry) begin
			// reserved bit 5 is dropped even if the core hands it over set [RULE20]
			saved_status_word <= i_entry.status & SSW_CAPTURE_MASK; // [RULE5] [RULE6] [RULE8]
		end else if (wr_ok && i_req.addr == OFF_SAVED_STATUS) begin
			// bit 8 keeps its captured value, reserved bit 5 stays zero [RULE9] [RULE7] [RULE20]
			saved_status_word <= (i_req.wdata[STATUS_W-1:0] & SSW_WRITE_MASK)
				| (saved_status_word & ~SSW_WRITE_MASK);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			saved_program_counter <= '0;
		end else if (i_dbg_entry) begin
			saved_program_counter <= i_entry.pc; // [RULE10]
		end else if (wr_ok && i_req.addr == OFF_SAVED_PC) begin
			saved_program_counter <= i_req.wdata; // [RULE10]
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			saved_stack_pointer <= '0;
		end else if (i_dbg_entry) begin
			saved_stack_pointer <= i_entry.sp; // [RULE11]
		end else if (wr_ok && i_req.addr == OFF_SAVED_SP) begin
			saved_stack_pointer <= i_req.wdata; // [RULE11]
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			read_thread_field <= '0;
			read_reg_field <= '0;
		end else begin
			if (wr_ok && i_req.addr == OFF_THREAD_SEL) begin
				read_thread_field <= i_req.wdata[THREAD_W-1:0]; // [RULE12]
			end
			if (wr_ok && i_req.addr == OFF_REG_SEL) begin
				read_reg_field <= i_req.wdata[REGSEL_W-1:0]; // [RULE13]
			end
		end
	end

	// lowest-numbered hit wins; host and call entries carry no trigger number
	always_comb begin
		next_trig = '0;
		for (int i = NUM_TRIG - 1; i >= 0; i--) begin
			if (i_trig_hits[i]) begin
				next_trig = TRIG_W'(i); // [RULE16]
			end
		end
		if (i_entry_cause == TDSR_CAUSE_HOST || i_entry_cause == TDSR_CAUSE_CALL) begin
			next_trig = '0; // [RULE15]
		end
		next_thread = (i_entry_cause == TDSR_CAUSE_HOST) ? '0 : i_entry.thread; // [RULE17]
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cause_code <= TDSR_CAUSE_NONE; // [RULE14]
			cause_thread <= '0;
			cause_trig <= '0;
		end else if (i_dbg_entry) begin
			cause_code <= i_entry_cause; // [RULE14]
			cause_thread <= next_thread;
			cause_trig <= next_trig;
		end else if (wr_ok && i_req.addr == OFF_ENTRY_CAUSE) begin
			cause_code <= i_req.wdata[CAUSE_LSB +: CAUSE_W];
			cause_thread <= i_req.wdata[THREAD_LSB +: THREAD_W];
			cause_trig <= i_req.wdata[TRIG_LSB +: TRIG_W];
		end
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		next_rdata = '0;
		if (i_req.addr == OFF_RING_CORE_CELL) begin
			next_rdata[RING_W-1:0] = ring_counter_value[0]; // [RULE1] [RULE3]
		end else if (i_req.addr == OFF_RING_CORE_WIRE) begin
			next_rdata[RING_W-1:0] = ring_counter_value[1]; // [RULE3]
		end else if (i_req.addr == OFF_RING_PERIPH_CELL) begin
			next_rdata[RING_W-1:0] = ring_counter_value[2]; // [RULE3]
		end else if (i_req.addr == OFF_RING_PERIPH_WIRE) begin
			next_rdata[RING_W-1:0] = ring_counter_value[3]; // [RULE3]
		end else if (i_req.addr == OFF_MEMORY_SIZE) begin
			next_rdata[DATA_W-1:MEM_LSB] = MEMORY_BYTES[DATA_W-1:MEM_LSB]; // [RULE4]
		end else if (i_req.addr == OFF_SAVED_STATUS) begin
			next_rdata[STATUS_W-1:0] = saved_status_word; // [RULE20]
		end else if (i_req.addr == OFF_SAVED_PC) begin
			next_rdata = saved_program_counter;
		end else if (i_req.addr == OFF_SAVED_SP) begin
			next_rdata = saved_stack_pointer;
		end else if (i_req.addr == OFF_THREAD_SEL) begin
			next_rdata[THREAD_W-1:0] = read_thread_field;
		end else if (i_req.addr == OFF_REG_SEL) begin
			next_rdata[REGSEL_W-1:0] = read_reg_field;
		end else if (i_req.addr == OFF_ENTRY_CAUSE) begin
			next_rdata[CAUSE_LSB +: CAUSE_W] = cause_code;
			next_rdata[THREAD_LSB +: THREAD_W] = cause_thread;
			next_rdata[TRIG_LSB +: TRIG_W] = cause_trig;
		end
	end

	// software must stop the oscillators before reading; no sync is done here [RULE18]
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= '0;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_req.rd;
			if (i_req.rd) begin
				o_rdata <= next_rdata;
			end
		end
	end

	assign o_read_thread_field = read_thread_field;
	assign o_read_reg_field = read_reg_field;
endmodule : tdsr_bank

// ### verification/tdsr_bank_asserts.sv
// checker: port-level properties of the debug status register bank
`timescale 1ns/1ps
module tdsr_bank_asserts
	import tdsr_pkg::*;
#(
	parameter logic [DATA_W-1:0] MEMORY_BYTES = 32'h0008_0000
) (
	input logic i_clk,
	input logic i_rst_b,
	input tdsr_req_t i_req,
	input logic [DATA_W-1:0] o_rdata,
	input logic o_rvalid,
	input logic i_debug_mode,
	input logic i_dbg_entry,
	input tdsr_entry_t i_entry,
	input tdsr_cause_t i_entry_cause,
	input logic [THREAD_W-1:0] o_read_thread_field
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// a read that meets a capture returns the value held before it, so it is left out
	logic rd;
	logic [ADDR_W-1:0] a;
	assign rd = i_req.rd && !i_dbg_entry;
	assign a = i_req.addr;
	property p_rv; o_rvalid == $past(i_req.rd); endproperty
	a_rv: assert property (p_rv) else $error("bad read strobe");
	property p_ring; rd && a inside {[8'h07:8'h0A]} |=> o_rdata[31:16] == 16'h0; endproperty
	a_ring: assert property (p_ring) else $error("ring upper bits");
	property p_mem; rd && a == OFF_MEMORY_SIZE |=> o_rdata == {MEMORY_BYTES[31:2], 2'b00}; endproperty
	a_mem: assert property (p_mem) else $error("memory size");
	property p_pc; i_dbg_entry ##1 rd && a == OFF_SAVED_PC |=> o_rdata == $past(i_entry.pc, 2); endproperty
	a_pc: assert property (p_pc) else $error("saved pc");
	property p_sp; i_dbg_entry ##1 rd && a == OFF_SAVED_SP |=> o_rdata == $past(i_entry.sp, 2); endproperty
	a_sp: assert property (p_sp) else $error("saved sp");
	property p_thr; i_req.wr && i_debug_mode && a == OFF_THREAD_SEL
		|=> o_read_thread_field == $past(i_req.wdata[7:0]); endproperty
	a_thr: assert property (p_thr) else $error("thread select");
	property p_host; i_dbg_entry && i_entry_cause == TDSR_CAUSE_HOST ##1 rd && a == OFF_ENTRY_CAUSE
		|=> o_rdata[17:8] == 10'h0; endproperty
	a_host: assert property (p_host) else $error("host cause fields");
	property p_ssw; rd && a == OFF_SAVED_STATUS |=> o_rdata[31:11] == 21'h0 && !o_rdata[5]; endproperty
	a_ssw: assert property (p_ssw) else $error("status reserved bits");
endmodule : tdsr_bank_asserts

// ### verification/tdsr_osc_model.sv
// partner: ring oscillator edges as seen in the core clock domain
`timescale 1ns/1ps
module tdsr_osc_model (
	input logic i_clk,
	output logic [3:0] o_tick
);
	initial o_tick = 4'h0;
	// unrelated oscillators, so edges land at random
	always @(posedge i_clk) o_tick <= 4'($urandom);
endmodule : tdsr_osc_model

// ### verification/testbench.sv
// testbench: register bank against a behavioural model
`timescale 1ns/1ps
module testbench;
	import tdsr_pkg::*;
	localparam logic [31:0] MEMB = 32'h0004_1003;
	logic i_clk, i_rst_b, i_por_b, dm, core, per, ent;
	logic [3:0] tick, hits;
	logic [31:0] o_rdata, mdl [256];
	logic [7:0] o_read_thread_field, a8;
	logic [4:0] o_read_reg_field;
	logic o_rvalid;
	tdsr_req_t req;
	tdsr_entry_t ev;
	tdsr_cause_t cs;
	int cnt [4];
	int bad_count, tests_run;
	tdsr_bank #(.MEMORY_BYTES(MEMB)) DUT (.i_clk, .i_rst_b, .i_por_b, .i_req(req), .o_rdata,
		.o_rvalid, .i_debug_mode(dm), .i_core_osc_run(core), .i_periph_osc_run(per),
		.i_ring_tick(tick), .i_dbg_entry(ent), .i_entry(ev), .i_entry_cause(cs),
		.i_trig_hits(hits), .o_read_thread_field, .o_read_reg_field);
	tdsr_osc_model u_osc (.i_clk, .o_tick(tick));
	always @(posedge i_clk or negedge i_por_b)
		if (!i_por_b) cnt <= '{default: 0};
		else for (int i = 0; i < 4; i++) if (tick[i] && (i < 2 ? core : per)) cnt[i] <= cnt[i] + 1;
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	function automatic logic [31:0] ex(input logic [7:0] a);
		if (a > 8'h06 && a < 8'h0B) return 32'(cnt[a - 8'h07] & 32'hFFFF);
		if (a == OFF_MEMORY_SIZE) return MEMB & 32'hFFFF_FFFC;
		return mdl[a];
	endfunction : ex
	task automatic rd(input logic [7:0] a);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge i_clk);
		req.rd <= 1'b0;
		#1;
		chk("rvalid", 32'(1), 32'(o_rvalid));
		chk("rdata", ex(a), o_rdata);
		chk("thread", mdl[8'h13], 32'(o_read_thread_field));
		chk("regsel", mdl[8'h14], 32'(o_read_reg_field));
		@(posedge i_clk);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] m;
		m = a == 8'h10 ? 32'h6DF : a == 8'h13 ? 32'hFF : a == 8'h14 ? 32'h1F : 32'h0;
		if (a inside {8'h11, 8'h12}) m = 32'hFFFF_FFFF;
		if (a == 8'h15) m = 32'h3_FF07;
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge i_clk);
		req.wr <= 1'b0;
		if (dm) mdl[a] = mdl[a] & ~m | d & m;
	endtask : wr
	task automatic entry(input logic [2:0] c);
		tdsr_entry_t e;
		logic [3:0] h;
		logic [1:0] t;
		logic [7:0] o [3];
		e = {11'($urandom), $urandom, $urandom, 8'($urandom)};
		h = 4'($urandom) | (4'h1 << $urandom % 4);
		t = h[0] ? 2'd0 : h[1] ? 2'd1 : h[2] ? 2'd2 : 2'd3;
		o = '{8'h12, 8'h15, 8'h11};
		{ev, cs, hits, ent} <= {e, tdsr_cause_t'(c), h, 1'b1};
		@(posedge i_clk);
		ent <= 1'b0;
		mdl[8'h10] = 32'(e.status & 11'h7DF);
		mdl[8'h11] = e.pc;
		mdl[8'h12] = e.sp;
		mdl[8'h15] = {14'h0, c > 2 ? t : 2'd0, c == 1 ? 8'h0 : e.thread, 5'h0, c};
		for (int k = 0; k < 3; k++) rd(o[(c + k) % 3]);
		rd(8'h10);
	endtask : entry
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	initial begin
		void'($urandom(92));
		{i_rst_b, i_por_b, dm, core, per, ent, hits, req, ev} = '0;
		cs = TDSR_CAUSE_NONE;
		mdl = '{default: 0};
		repeat (4) @(posedge i_clk);
		{i_rst_b, i_por_b} <= 2'b11;
		@(posedge i_clk);
		for (int a = 7; a < 22; a++) rd(8'(a));
		repeat (60) begin
			a8 = 8'(7 + $urandom % 15);
			dm <= 1'($urandom);
			wr(a8, $urandom);
			rd(a8);
		end
		$display("test access done");
		for (int c = 1; c < 6; c++) entry(3'(c));
		$display("test entry done");
		core <= 1'b1;
		repeat (40) @(posedge i_clk) per <= 1'($urandom);
		{core, per} <= 2'b00;
		// counts are only stable once the oscillators have been quiet a while
		repeat (10) @(posedge i_clk);
		for (int a = 7; a < 11; a++) rd(8'(a));
		i_rst_b <= 1'b0;
		@(posedge i_clk);
		i_rst_b <= 1'b1;
		mdl = '{default: 0};
		@(posedge i_clk);
		for (int a = 7; a < 22; a++) rd(8'(a));
		i_por_b <= 1'b0;
		@(posedge i_clk);
		i_por_b <= 1'b1;
		@(posedge i_clk);
		for (int a = 7; a < 11; a++) rd(8'(a));
		$display("test ring done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		give_verdict();
	end
endmodule : testbench
bind tdsr_bank tdsr_bank_asserts #(.MEMORY_BYTES(MEMORY_BYTES)) u_chk (.i_clk, .i_rst_b, .i_req,
	.o_rdata, .o_rvalid, .i_debug_mode, .i_dbg_entry, .i_entry, .i_entry_cause,
	.o_read_thread_field);
